// ---- pkg/sim_regs.vh ----
// Register layout and timing counts of the system integrity monitor.
// Included by the monitor top and its clock supervisor.
`ifndef SIM_REGS_VH
`define SIM_REGS_VH
`define SIM_CSR_ADDR 8'h00
`define SIM_CSR_RESET 8'h00
`define SIM_BIT_SRC 7
`define SIM_BIT_DIE 6
`define SIM_BIT_DFLAG 5
`define SIM_BIT_LVRF 4
`define SIM_BIT_RSVD 3
`define SIM_BIT_CFIE 2
`define SIM_BIT_CFF 1
`define SIM_BIT_WDRF 0
`define SIM_CLK_PERIOD_NS 10
`define SIM_DLY_SHORT_CYC 256
`define SIM_DLY_LONG_CYC 4096
`define SIM_DLY_W 13
// Time without an oscillator edge before the safe clock takes over
`define SIM_OSC_LOSS_NS 640
`define SIM_OSC_LOSS_CYC (`SIM_OSC_LOSS_NS / `SIM_CLK_PERIOD_NS)
`define SIM_LOSS_W 8
`endif

// ---- core/sim_clkmon.v ----
// Clock supervisor: glitch filter and loss detector for the main oscillator.
// Assumes osc_in is asynchronous and slower than half of clk.
`timescale 1ns/10ps
`include "sim_regs.vh"
module sim_clkmon
(
   input wire clk,
   input wire rst_n,
   input wire osc_in,
   input wire mon_en,
   input wire filt_en,
   output reg safe_sel_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg filt_q;
   reg filt_prev_q;
   reg [`SIM_LOSS_W-1:0] idle_q;
   wire edge_seen;
   wire [31:0] loss_full;
   wire [`SIM_LOSS_W-1:0] loss_lim;
   assign loss_full = `SIM_OSC_LOSS_CYC;
   // Timeout fits the idle counter, upper bits dropped on purpose
   assign loss_lim = loss_full[`SIM_LOSS_W-1:0];
   assign edge_seen = filt_q ^ filt_prev_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         filt_q <= 1'b0;
         filt_prev_q <= 1'b0;
         idle_q <= {`SIM_LOSS_W{1'b0}};
         safe_sel_q <= 1'b0;
      end
      else
      begin
         s1_q <= osc_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // R12 filter isolated glitches
         if (!filt_en || (s2_q == s3_q))
            filt_q <= s2_q;
         filt_prev_q <= filt_q;
         if (!mon_en)
         begin
            // Halted or disabled: detector cleared, safe clock released
            idle_q <= {`SIM_LOSS_W{1'b0}};
            safe_sel_q <= 1'b0;
         end
         else if (edge_seen)
         begin
            idle_q <= {`SIM_LOSS_W{1'b0}};
            // R14 switch back on recovery
            safe_sel_q <= 1'b0;
         end
         else if (idle_q == loss_lim)
            // R13 fall back to safe clock
            safe_sel_q <= 1'b1;
         else
            idle_q <= idle_q + 1'b1;
      end
   end
endmodule // sim_clkmon

// ---- core/sim_top.v ----
// System integrity monitor: low-voltage reset, voltage detector, clock security.
// Assumes APB master on pclk; comparator and oscillator inputs asynchronous.
// Operation
// R1 - Static reset below rising threshold going up, falling threshold going down
// R2 - Drive reset pin low while low-voltage reset is active
// R3 - No low-voltage reset unless enabled by option
// R4 - Detector flag follows comparator in real time; writes ignored
// R5 - Detector works only when low-voltage reset option is on
// R6 - Source select: 0 main supply, 1 external detect pin; read/write
// R7 - With enable set, interrupt on every detector flag change
// R8 - No detector interrupt for crossings inside the reset delay
// R9 - Enabling while flag set gives one interrupt at enable
// R10 - Detector pending clears on service routine entry
// R11 - Detector flag hardware only: 0 above, 1 below threshold
// R12 - Filter oscillator glitches only when multiplier enabled
// R13 - On oscillator loss switch to safe oscillator
// R14 - On oscillator recovery switch back to main clock
// R15 - Clock-fail flag set on safe clock; interrupt if enabled
// R16 - Events wake from wait but not from halt
// R17 - Halt disables clock security; configuration kept
// R18 - Event reaches CPU only when enabled and global mask clear
// R19 - Reserved bit 3 reads zero; register resets to zero
// R20 - Low-voltage flag set by that reset, cleared writing zero
// R21 - Clock-fail enable read/write, no effect without option
// R22 - Clock-fail flag clears on read after recovery; zero without option
// R23 - Watchdog flag set by watchdog reset, cleared by write or LOW_VOLTAGE_RESET_UNIT
// R24 - Low-voltage flag survives later external or watchdog resets
// R25 - Register read and written in one bus access
`timescale 1ns/10ps
`include "sim_regs.vh"
module sim_top
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q,
   input wire opt_lvd_en,
   input wire opt_long_delay,
   input wire opt_css_en,
   input wire opt_pll_en,
   input wire supply_below_rise,
   input wire supply_below_fall,
   input wire det_supply_low,
   input wire det_pin_low,
   input wire main_osc,
   input wire wdg_reset_evt,
   input wire det_isr_enter,
   input wire cc_irq_mask,
   input wire wait_mode,
   input wire halt_mode,
   input wire rst_pin_in,
   output reg rst_pin_out_q,
   output reg rst_pin_oe_q,
   output reg lvd_reset_q,
   output reg safe_clk_sel_q,
   output reg safe_osc_en_q,
   output reg det_irq_q,
   output reg clk_fail_irq_q,
   output reg wait_wake_q
);
   // Comparator synchronisers
   reg [3:0] cmp1_q;
   reg [3:0] cmp2_q;
   wire below_rise;
   wire below_fall;
   wire det_vdd;
   wire det_pin;
   reg rst_pin1_q;
   reg rst_pin2_q;
   // Register fields
   reg src_sel_q;
   reg det_ie_q;
   reg lvrf_q;
   reg cf_ie_q;
   reg cff_q;
   reg wdrf_q;
   // Detector state
   reg det_flag_q;
   reg det_prev_q;
   reg det_pend_q;
   reg det_ie_prev_q;
   reg [`SIM_DLY_W-1:0] dly_q;
   reg quiet_q;
   // Clock security
   wire safe_sel;
   wire css_run;
   // Bus decode
   wire acc;
   wire hit;
   wire wr_ok;
   wire rd_ok;
   wire [7:0] csr_val;
   wire det_raw;
   wire det_evt;
   wire det_en_rise;
   wire cf_req;
   wire det_req;
   wire [31:0] dly_long;
   wire [31:0] dly_short;
   wire [`SIM_DLY_W-1:0] dly_lim;
   assign below_rise = cmp2_q[0];
   assign below_fall = cmp2_q[1];
   assign det_vdd = cmp2_q[2];
   assign det_pin = cmp2_q[3];
   assign acc = psel & penable;
   assign hit = (paddr == `SIM_CSR_ADDR);
   // R25 single access
   assign wr_ok = acc & pready_q & pwrite & hit;
   assign rd_ok = acc & pready_q & ~pwrite & hit;
   // Both counts fit the window counter, cut to its width on purpose
   assign dly_long = `SIM_DLY_LONG_CYC;
   assign dly_short = `SIM_DLY_SHORT_CYC;
   assign dly_lim = opt_long_delay ? dly_long[`SIM_DLY_W-1:0] : dly_short[`SIM_DLY_W-1:0];
   // R6 source select
   assign det_raw = src_sel_q ? det_pin : det_vdd;
   // R7 change events, R8 suppressed in delay window
   assign det_evt = (det_flag_q != det_prev_q) & ~quiet_q;
   // R9 enable while below gives one request
   assign det_en_rise = det_ie_q & ~det_ie_prev_q & det_flag_q;
   // R21 enable inert without option
   assign cf_req = cff_q & cf_ie_q & opt_css_en;
   assign det_req = det_pend_q & det_ie_q & opt_lvd_en;
   // R17 halt disables clock security
   assign css_run = opt_css_en & ~halt_mode;
   // R19 reserved bit reads zero
   assign csr_val = {src_sel_q, det_ie_q, det_flag_q, lvrf_q,
                     1'b0, cf_ie_q, cff_q, wdrf_q};

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmp1_q <= 4'h0;
         cmp2_q <= 4'h0;
         rst_pin1_q <= 1'b1;
         rst_pin2_q <= 1'b1;
      end
      else
      begin
         cmp1_q <= {det_pin_low, det_supply_low, supply_below_fall, supply_below_rise};
         cmp2_q <= cmp1_q;
         rst_pin1_q <= rst_pin_in;
         rst_pin2_q <= rst_pin1_q;
      end
   end

   // Low-voltage reset with hysteresis
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvd_reset_q <= 1'b0;
         rst_pin_out_q <= 1'b0;
         rst_pin_oe_q <= 1'b0;
      end
      else
      begin
         rst_pin_out_q <= 1'b0;
         // R3 option gate
         if (!opt_lvd_en)
            lvd_reset_q <= 1'b0;
         // R1 rising threshold while held
         else if (lvd_reset_q)
            lvd_reset_q <= below_rise;
         // R1 falling threshold while running
         else
            lvd_reset_q <= below_fall;
         // R2 pull reset pin low
         rst_pin_oe_q <= opt_lvd_en & (lvd_reset_q | below_fall);
      end
   end

   // Reset delay window after the low-voltage reset lets go
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dly_q <= {`SIM_DLY_W{1'b0}};
         quiet_q <= 1'b1;
      end
      else if (lvd_reset_q || !rst_pin2_q)
      begin
         dly_q <= {`SIM_DLY_W{1'b0}};
         quiet_q <= 1'b1;
      end
      else if (quiet_q)
      begin
         // R8 window length follows option
         if (dly_q == dly_lim)
            quiet_q <= 1'b0;
         else
            dly_q <= dly_q + 1'b1;
      end
   end

   // Detector flag and pending request
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         det_flag_q <= 1'b0;
         det_prev_q <= 1'b0;
         det_pend_q <= 1'b0;
         det_ie_prev_q <= 1'b0;
      end
      else
      begin
         // R4 R11 hardware-only real-time flag, R5 option gate
         det_flag_q <= det_raw & opt_lvd_en;
         det_prev_q <= det_flag_q;
         det_ie_prev_q <= det_ie_q;
         // R10 set wins over service-entry clear
         if (det_ie_q && opt_lvd_en && (det_evt || det_en_rise))
            det_pend_q <= 1'b1;
         else if (det_isr_enter || !det_ie_q)
            det_pend_q <= 1'b0;
      end
   end

   sim_clkmon u_clkmon
   (
      .clk(pclk),
      .rst_n(presetn),
      .osc_in(main_osc),
      .mon_en(css_run),
      .filt_en(opt_pll_en),
      .safe_sel_q(safe_sel)
   );

   // Safe clock steering
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         safe_clk_sel_q <= 1'b0;
         safe_osc_en_q <= 1'b0;
      end
      else
      begin
         // R13 R14 follow the supervisor
         safe_clk_sel_q <= safe_sel & css_run;
         // R17 safe oscillator off in halt
         safe_osc_en_q <= css_run;
      end
   end

   // Register fields
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_sel_q <= 1'b0;
         det_ie_q <= 1'b0;
         cf_ie_q <= 1'b0;
      end
      else if (wr_ok)
      begin
         // R6 R21 software read/write bits
         src_sel_q <= pwdata[`SIM_BIT_SRC];
         det_ie_q <= pwdata[`SIM_BIT_DIE];
         cf_ie_q <= pwdata[`SIM_BIT_CFIE];
      end
   end

   // Reset cause flags
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvrf_q <= 1'b0;
         wdrf_q <= 1'b0;
      end
      else
      begin
         // R20 set by low-voltage reset, R24 no other reset clears it
         if (lvd_reset_q)
            lvrf_q <= 1'b1;
         else if (wr_ok && !pwdata[`SIM_BIT_LVRF])
            lvrf_q <= 1'b0;
         // R23 watchdog flag, set beats clear
         if (wdg_reset_evt)
            wdrf_q <= 1'b1;
         else if (lvd_reset_q)
            wdrf_q <= 1'b0;
         else if (wr_ok && !pwdata[`SIM_BIT_WDRF])
            wdrf_q <= 1'b0;
      end
   end

   // Clock-fail flag
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cff_q <= 1'b0;
      // R22 forced zero without option
      else if (!opt_css_en)
         cff_q <= 1'b0;
      // R15 set while on safe clock
      else if (safe_sel)
         cff_q <= 1'b1;
      // R22 read clears after recovery
      else if (rd_ok)
         cff_q <= 1'b0;
   end

   // Interrupt requests and wake-up
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         det_irq_q <= 1'b0;
         clk_fail_irq_q <= 1'b0;
         wait_wake_q <= 1'b0;
      end
      else
      begin
         // R18 enable and global mask
         det_irq_q <= det_req & ~cc_irq_mask;
         clk_fail_irq_q <= cf_req & ~cc_irq_mask;
         // R16 wake from wait only, never from halt
         wait_wake_q <= wait_mode & ~halt_mode & (det_req | cf_req);
      end
   end

   // APB slave with one wait state
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~hit;
         if (acc && !pready_q && hit && !pwrite)
            prdata_q <= {24'h00_0000, csr_val};
         else
            prdata_q <= 32'h0000_0000;
      end
   end
endmodule // sim_top

// ---- dv/sim_top_assertions.sv ----
// Checker for the monitor top: bus timing, reset pin, gating.
// Sees only top ports; bound to sim_top below.
`timescale 1ns/10ps
module sim_top_assertions
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire [31:0] prdata_q,
   input wire pready_q,
   input wire pslverr_q,
   input wire opt_lvd_en,
   input wire opt_css_en,
   input wire cc_irq_mask,
   input wire halt_mode,
   input wire rst_pin_out_q,
   input wire rst_pin_oe_q,
   input wire lvd_reset_q,
   input wire safe_clk_sel_q,
   input wire safe_osc_en_q,
   input wire det_irq_q,
   input wire clk_fail_irq_q
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && !pready_q;
   endsequence
   a_ready_wait: assert property (s_setup ##1 s_access |=> pready_q)
      else $error("ready late");
   a_ready_pulse: assert property (pready_q |=> !pready_q)
      else $error("ready not pulse");
   a_err_unmapped: assert property (pready_q |-> pslverr_q == (paddr != 8'h00))
      else $error("slverr wrong");
   a_rsvd_zero: assert property (pready_q |-> prdata_q[31:8] == 24'h0 && !prdata_q[3])
      else $error("reserved bits set");
   a_pin_drive: assert property (lvd_reset_q |-> rst_pin_oe_q && !rst_pin_out_q)
      else $error("pin not driven");
   a_lvd_gated: assert property (!opt_lvd_en |-> !lvd_reset_q && !det_irq_q)
      else $error("lvd without option");
   a_mask_blocks: assert property (cc_irq_mask [*3] |-> !det_irq_q && !clk_fail_irq_q)
      else $error("irq while masked");
   a_css_off: assert property (!opt_css_en |-> !safe_clk_sel_q && !clk_fail_irq_q)
      else $error("css without option");
   a_halt_safe: assert property (halt_mode [*3] |-> !safe_osc_en_q)
      else $error("safe osc in halt");
endmodule // sim_top_assertions

bind sim_top sim_top_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata_q(prdata_q), .pready_q(pready_q),
   .pslverr_q(pslverr_q), .opt_lvd_en(opt_lvd_en), .opt_css_en(opt_css_en),
   .cc_irq_mask(cc_irq_mask), .halt_mode(halt_mode), .rst_pin_out_q(rst_pin_out_q),
   .rst_pin_oe_q(rst_pin_oe_q), .lvd_reset_q(lvd_reset_q), .safe_clk_sel_q(safe_clk_sel_q),
   .safe_osc_en_q(safe_osc_en_q), .det_irq_q(det_irq_q), .clk_fail_irq_q(clk_fail_irq_q));

// ---- dv/sim_top_tb.sv ----
// Self-checking bench for the monitor top.
// Bench is the APB master and drives all comparator and mode levels.
`timescale 1ns/10ps
module sim_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata_q;
   logic pready_q, pslverr_q, rst_pin_out_q, rst_pin_oe_q, lvd_reset_q;
   logic safe_clk_sel_q, safe_osc_en_q, det_irq_q, clk_fail_irq_q, wait_wake_q;
   logic supply_below_rise = 0, supply_below_fall = 0, det_supply_low = 0;
   logic det_pin_low = 0, main_osc = 0, wdg_reset_evt = 0, det_isr_enter = 0;
   logic cc_irq_mask = 0, wait_mode = 0, halt_mode = 0, orun = 1;
   logic gl = 0, opt_lvd = 1, opt_css = 1;
   logic [1:0] oc = 2'h0;
   int failures = 0, num_checks = 0, cyc = 0;
   sim_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata_q, .pready_q, .pslverr_q, .opt_lvd_en(opt_lvd), .opt_long_delay(1'h0),
      .opt_css_en(opt_css), .opt_pll_en(1'h1), .supply_below_rise, .supply_below_fall,
      .det_supply_low, .det_pin_low, .main_osc, .wdg_reset_evt, .det_isr_enter,
      .cc_irq_mask, .wait_mode, .halt_mode, .rst_pin_in(1'h1), .rst_pin_out_q,
      .rst_pin_oe_q, .lvd_reset_q, .safe_clk_sel_q, .safe_osc_en_q, .det_irq_q,
      .clk_fail_irq_q, .wait_wake_q);
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   // Oscillator at a quarter of pclk, stoppable
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (orun)
         oc <= oc + 2'h1;
      // Glitch input flips the pin for one cycle
      main_osc <= oc[1] ^ gl;
      if (cyc == 6000)
      begin
         failures++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         failures++;
         $display("CHECK FAILED %s exp %h got %h", s, x, g);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr_en;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready_q !== 1'h1 && n < 20);
      r = prdata_q;
      e = pslverr_q;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20)
         chk("pready", 1, 0);
   endtask
   task wr(input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, 8'h00, d, r, e);
   endtask
   task rchk(input string s, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'h0, 8'h00, 32'h0, r, e);
      chk(s, x, r);
   endtask
   task isr;
      det_isr_enter <= 1'h1;
      @(posedge pclk);
      det_isr_enter <= 1'h0;
      w(3);
   endtask
   task t_regs;
      logic [31:0] r;
      logic e;
      rchk("csr reset", 32'h0);
      wr(32'hff);
      rchk("csr rw", 32'hc4);
      apb(1'h1, 8'h04, 32'h0, r, e);
      chk("slverr", 1, e);
      chk("err data", 0, r);
      rchk("csr kept", 32'hc4);
      wr(32'h80);
      det_pin_low <= 1'h1;
      w(10);
      rchk("pin src", 32'ha0);
      det_pin_low <= 1'h0;
      wr(32'h0);
   endtask
   task t_det;
      wr(32'h40);
      det_supply_low <= 1'h1;
      wait_mode <= 1'h1;
      w(8);
      chk("det rise", 1, det_irq_q);
      chk("wake", 1, wait_wake_q);
      isr();
      chk("isr clear", 0, det_irq_q);
      wait_mode <= 1'h0;
      det_supply_low <= 1'h0;
      w(8);
      chk("det fall", 1, det_irq_q);
      isr();
      wr(32'h0);
      det_supply_low <= 1'h1;
      w(8);
      wr(32'h40);
      w(3);
      chk("enable irq", 1, det_irq_q);
      isr();
      cc_irq_mask <= 1'h1;
      det_supply_low <= 1'h0;
      w(8);
      chk("masked", 0, det_irq_q);
      cc_irq_mask <= 1'h0;
      isr();
      wr(32'h0);
   endtask
   task t_css;
      wr(32'h04);
      orun <= 1'h0;
      w(80);
      chk("safe sel", 1, safe_clk_sel_q);
      chk("cf irq", 1, clk_fail_irq_q);
      rchk("cf flag", 32'h06);
      gl <= 1'h1;
      @(posedge pclk);
      gl <= 1'h0;
      w(8);
      chk("glitch held", 1, safe_clk_sel_q);
      orun <= 1'h1;
      w(20);
      chk("back main", 0, safe_clk_sel_q);
      halt_mode <= 1'h1;
      wait_mode <= 1'h1;
      w(4);
      chk("halt osc", 0, safe_osc_en_q);
      chk("halt wake", 0, wait_wake_q);
      halt_mode <= 1'h0;
      wait_mode <= 1'h0;
      rchk("cf recovered", 32'h06);
      rchk("cf cleared", 32'h04);
      wr(32'h0);
   endtask
   task t_lvd;
      supply_below_rise <= 1'h1;
      w(6);
      chk("lvd between", 0, lvd_reset_q);
      supply_below_fall <= 1'h1;
      w(6);
      chk("lvd on", 1, lvd_reset_q);
      chk("pin oe", 1, rst_pin_oe_q);
      supply_below_fall <= 1'h0;
      w(6);
      chk("lvd held", 1, lvd_reset_q);
      supply_below_rise <= 1'h0;
      w(6);
      chk("lvd off", 0, lvd_reset_q);
      wdg_reset_evt <= 1'h1;
      @(posedge pclk);
      wdg_reset_evt <= 1'h0;
      w(2);
      rchk("flags", 32'h11);
      wr(32'h0);
      rchk("flags clr", 32'h0);
      // Still inside the delay window after the low-voltage reset
      wr(32'h40);
      det_supply_low <= 1'h1;
      w(8);
      chk("delay window", 0, det_irq_q);
      det_supply_low <= 1'h0;
      wr(32'h0);
   endtask
   task t_opt;
      wr(32'h44);
      opt_lvd <= 1'h0;
      opt_css <= 1'h0;
      supply_below_rise <= 1'h1;
      supply_below_fall <= 1'h1;
      det_supply_low <= 1'h1;
      orun <= 1'h0;
      w(80);
      chk("lvd opt off", 0, lvd_reset_q);
      chk("pin opt off", 0, rst_pin_oe_q);
      chk("det opt off", 0, det_irq_q);
      chk("cf opt off", 0, clk_fail_irq_q);
      chk("safe opt off", 0, safe_clk_sel_q);
      rchk("csr opt off", 32'h44);
      supply_below_rise <= 1'h0;
      supply_below_fall <= 1'h0;
      det_supply_low <= 1'h0;
      orun <= 1'h1;
      w(4);
      opt_lvd <= 1'h1;
      opt_css <= 1'h1;
      w(4);
      wr(32'h0);
   endtask
   initial
   begin
      w(2);
      presetn <= 1'h1;
      t_regs();
      // Outside the start-up delay window
      w(300);
      t_det();
      t_css();
      t_lvd();
      t_opt();
      end_of_test();
   end
endmodule // sim_top_tb
